// >>> src/sisi_defs.svh
// Constants for the sense interleave, status word and interrupt block
`ifndef SISI_DEFS_SVH
`define SISI_DEFS_SVH
`define SISI_NSRC 16
`define SISI_SENSE_W 16
`define SISI_SRC_TSD_BGN 0
`define SISI_SRC_TSD_END 1
`define SISI_SRC_PWRUP 2
`define SISI_SRC_SPK_OVC 3
`define SISI_SRC_DHT_BGN 4
`define SISI_SRC_DHT_END 5
`define SISI_SRC_FB_END 6
`define SISI_SRC_FB_BGN 7
`define SISI_SRC_TW2_END 8
`define SISI_SRC_TW2_BGN 9
`define SISI_SRC_TW1_END 10
`define SISI_SRC_TW1_BGN 11
`define SISI_SRC_BPE_ACT_END 12
`define SISI_SRC_BPE_ACT_BGN 13
`define SISI_SRC_BPE_LVL 14
`define SISI_SRC_BPE_L0 15
`define SISI_STAT_LSB 2
`define SISI_STAT_MSB 15
`define SISI_BIT_IDX_MAX 6'h3f
`define SISI_RST_WORD 16'h0000
`endif

// >>> src/sisi_irq_bank.sv
// Per-source raw edge, sticky state and flag logic
`timescale 1ns/10ps
`include "sisi_defs.svh"
module sisi_irq_bank (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [`SISI_NSRC-1:0] raw_i,
    input wire logic [`SISI_NSRC-1:0] enable_i,
    input wire logic [`SISI_NSRC-1:0] clear_i,
    output logic [`SISI_NSRC-1:0] state_o,
    output logic [`SISI_NSRC-1:0] flag_o,
    output logic [`SISI_NSRC-1:0] rise_o
);
    import sisi_pkg::*;
    sisi_bank_st_t st_q;
    sisi_bank_st_t st_d;

    genvar g;
    generate
        for (g = 0; g < `SISI_NSRC; g++) begin : g_src
            assign rise_o[g] = raw_i[g] & ~st_q.raw_prev[g];
            // Flag follows enable at once, so a late enable raises it
            assign flag_o[g] = st_q.state[g] & enable_i[g];
        end
    endgenerate
    assign state_o = st_q.state;

    always_comb begin
        st_d = st_q;
        st_d.raw_prev = raw_i;
        // Edge beats a clear in the same cycle, so no event is lost
        st_d.state = (st_q.state & ~clear_i) | rise_o;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// >>> src/sisi_pkg.sv
// Types for the sense interleave, status word and interrupt block
package sisi_pkg;
    typedef enum logic [1:0] {
        SISI_CT_NONE = 2'b00,
        SISI_CT_VOLT = 2'b01,
        SISI_CT_CURR = 2'b11,
        SISI_CT_STAT = 2'b10
    } sisi_chan_type_t;
    typedef enum logic {SISI_PH_VOLT = 1'b0, SISI_PH_CURR = 1'b1} sisi_phase_t;
    typedef struct packed {
        logic bpe_l0;
        logic bpe_lvl_chg;
        logic bpe_act_bgn;
        logic bpe_act_end;
        logic fb_bgn;
        logic fb_end;
        logic dht_act_bgn;
        logic dht_act_end;
        logic spk_ovc;
        logic pwrup_done;
    } sisi_misc_raw_t;
    typedef struct packed {
        logic over_shdn;
        logic over_warn1;
        logic over_warn2;
    } sisi_temp_t;
    typedef struct packed {
        logic valid;
        logic [15:0] v;
        logic [15:0] i;
    } sisi_sense_t;
    typedef struct packed {
        logic tx_en;
        logic interleave_en;
        logic interleave_chan;
        logic padding_bits_tristate_select;
        logic unused_slot_tristate_select;
        sisi_chan_type_t [1:0] ch_type;
    } sisi_tx_cfg_t;
    typedef struct packed {
        logic [15:0] raw_prev;
        logic [15:0] state;
    } sisi_bank_st_t;
endpackage

// >>> src/sisi_top.sv
// Interleaved sense output, status word and interrupt pin logic
`timescale 1ns/10ps
`include "sisi_defs.svh"
module sisi_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire sisi_pkg::sisi_misc_raw_t misc_raw_i,
    input wire sisi_pkg::sisi_temp_t temp_level_i,
    input wire logic [`SISI_NSRC-1:0] irq_enable_i,
    input wire logic [`SISI_NSRC-1:0] source_clear_bit_i,
    input wire logic irq_pin_drive_mode_i,
    input wire logic irq_pin_polarity_i,
    input wire logic [1:0] irq_pin_drive_strength_i,
    input wire sisi_pkg::sisi_sense_t sense_i,
    input wire sisi_pkg::sisi_tx_cfg_t tx_cfg_i,
    output logic [`SISI_NSRC-1:0] raw_o,
    output logic [`SISI_NSRC-1:0] state_o,
    output logic [`SISI_NSRC-1:0] flag_o,
    output logic irq_o,
    output logic irq_oe,
    output logic [1:0] irq_strength_o,
    input wire logic bclk,
    input wire logic lrclk_i,
    output logic dout_o,
    output logic dout_oe
);
    import sisi_pkg::*;

    typedef struct packed {
        logic [2:0] therm_seen;
        logic [15:0] tog;
        logic [15:0] hold_v;
        logic [15:0] hold_i;
        logic sense_tog;
        logic irq;
        logic irq_oe;
        logic [1:0] strength;
    } sisi_core_st_t;

    typedef struct packed {
        sisi_tx_cfg_t cfg_s1;
        sisi_tx_cfg_t cfg_s2;
        logic [15:0] tog_s1;
        logic [15:0] tog_s2;
        logic [15:0] tog_seen;
        logic [15:0] pend;
        logic [15:0] stat;
        logic stog_s1;
        logic stog_s2;
        logic stog_seen;
        logic [15:0] rx_v;
        logic [15:0] rx_i;
        logic rx_new;
        logic [15:0] tx_v;
        logic [15:0] tx_i;
        sisi_phase_t phase;
        logic lr_q;
        logic lr_qq;
        logic chan;
        logic [5:0] bit_idx;
        logic dout;
        logic doe;
    } sisi_link_st_t;

    sisi_core_st_t c_q;
    sisi_core_st_t c_d;
    sisi_link_st_t l_q;
    sisi_link_st_t l_d;
    logic [`SISI_NSRC-1:0] raw_w;
    logic [`SISI_NSRC-1:0] rise_w;
    logic [15:0] new_ev;
    logic lr_edge;
    logic frame_start;
    logic [16:0] word_w;
    logic [16:0] word_chk;

    // Returns {valid, word} for one channel of the current frame
    function automatic logic [16:0] chan_word(input sisi_link_st_t s, input logic c);
        logic [16:0] w;
        w = '0;
        if (s.cfg_s2.interleave_en && (c == s.cfg_s2.interleave_chan)) begin
            if (s.phase == SISI_PH_VOLT) begin
                w = {1'b1, 1'b0, s.tx_v[15:1]};
            end else begin
                w = {1'b1, 1'b1, s.tx_i[15:1]};
            end
        end else begin
            unique case (s.cfg_s2.ch_type[c])
                SISI_CT_NONE: w = '0;
                SISI_CT_VOLT: w = {1'b1, s.tx_v};
                SISI_CT_CURR: w = {1'b1, s.tx_i};
                SISI_CT_STAT: w = {1'b1, s.stat};
            endcase
        end
        return w;
    endfunction

    // Raw source vector; thermal end sources need a remembered over-threshold level
    always_comb begin
        raw_w = '0;
        raw_w[`SISI_SRC_TSD_BGN] = temp_level_i.over_shdn;
        raw_w[`SISI_SRC_TSD_END] = c_q.therm_seen[0] & ~temp_level_i.over_shdn;
        raw_w[`SISI_SRC_TW1_BGN] = temp_level_i.over_warn1;
        raw_w[`SISI_SRC_TW1_END] = c_q.therm_seen[1] & ~temp_level_i.over_warn1;
        raw_w[`SISI_SRC_TW2_BGN] = temp_level_i.over_warn2;
        raw_w[`SISI_SRC_TW2_END] = c_q.therm_seen[2] & ~temp_level_i.over_warn2;
        raw_w[`SISI_SRC_BPE_L0] = misc_raw_i.bpe_l0;
        raw_w[`SISI_SRC_BPE_LVL] = misc_raw_i.bpe_lvl_chg;
        raw_w[`SISI_SRC_BPE_ACT_BGN] = misc_raw_i.bpe_act_bgn;
        raw_w[`SISI_SRC_BPE_ACT_END] = misc_raw_i.bpe_act_end;
        raw_w[`SISI_SRC_FB_BGN] = misc_raw_i.fb_bgn;
        raw_w[`SISI_SRC_FB_END] = misc_raw_i.fb_end;
        raw_w[`SISI_SRC_DHT_BGN] = misc_raw_i.dht_act_bgn;
        raw_w[`SISI_SRC_DHT_END] = misc_raw_i.dht_act_end;
        raw_w[`SISI_SRC_SPK_OVC] = misc_raw_i.spk_ovc;
        raw_w[`SISI_SRC_PWRUP] = misc_raw_i.pwrup_done;
    end
    assign raw_o = raw_w;

    sisi_irq_bank u_bank (
        .clk(clk),
        .reset_n(reset_n),
        .raw_i(raw_w),
        .enable_i(irq_enable_i),
        .clear_i(source_clear_bit_i),
        .state_o(state_o),
        .flag_o(flag_o),
        .rise_o(rise_w)
    );

    always_comb begin
        logic any_flag;
        logic lvl;
        any_flag = 1'b0;
        lvl = 1'b0;
        c_d = c_q;
        c_d.therm_seen = c_q.therm_seen |
            {temp_level_i.over_warn2, temp_level_i.over_warn1, temp_level_i.over_shdn};
        // Each edge flips a toggle so the link clock can see it
        c_d.tog = c_q.tog ^ rise_w;
        if (sense_i.valid) begin
            c_d.hold_v = sense_i.v;
            c_d.hold_i = sense_i.i;
            c_d.sense_tog = ~c_q.sense_tog;
        end
        any_flag = |flag_o;
        lvl = any_flag ? irq_pin_polarity_i : ~irq_pin_polarity_i;
        // Open drain can only pull low; a high level is left to the pull-up
        c_d.irq = irq_pin_drive_mode_i ? lvl : 1'b0;
        c_d.irq_oe = irq_pin_drive_mode_i | ~lvl;
        c_d.strength = irq_pin_drive_mode_i ? irq_pin_drive_strength_i : 2'b00;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end
    assign irq_o = c_q.irq;
    assign irq_oe = c_q.irq_oe;
    assign irq_strength_o = c_q.strength;

    // Link side; lrclk belongs to bclk, so it needs one flop, not two
    assign lr_edge = l_q.lr_q ^ l_q.lr_qq;
    assign frame_start = lr_edge & ~l_q.lr_q;
    assign new_ev = l_q.tog_s2 ^ l_q.tog_seen;

    always_comb begin
        l_d = l_q;
        // Config is quasi-static; change it only while the output is disabled
        l_d.cfg_s1 = tx_cfg_i;
        l_d.cfg_s2 = l_q.cfg_s1;
        l_d.tog_s1 = c_q.tog;
        l_d.tog_s2 = l_q.tog_s1;
        l_d.tog_seen = l_q.tog_s2;
        l_d.stog_s1 = c_q.sense_tog;
        l_d.stog_s2 = l_q.stog_s1;
        l_d.stog_seen = l_q.stog_s2;
        l_d.lr_q = lrclk_i;
        l_d.lr_qq = l_q.lr_q;
        // New edges land in the next frame; set beats the frame clear
        l_d.pend = (frame_start ? `SISI_RST_WORD : l_q.pend) | new_ev;
        if (frame_start) begin
            l_d.stat = {l_q.pend[`SISI_STAT_MSB:`SISI_STAT_LSB], 2'b00};
            if (l_q.rx_new) begin
                l_d.tx_v = l_q.rx_v;
                l_d.tx_i = l_q.rx_i;
                l_d.rx_new = 1'b0;
                l_d.phase = SISI_PH_VOLT;
            end else begin
                l_d.phase = SISI_PH_CURR;
            end
        end
        // Held words are stable for at least two bclk cycles before the toggle arrives
        if (l_q.stog_s2 ^ l_q.stog_seen) begin
            l_d.rx_v = c_q.hold_v;
            l_d.rx_i = c_q.hold_i;
            l_d.rx_new = 1'b1;
        end
        if (lr_edge) begin
            l_d.chan = l_q.lr_q;
            l_d.bit_idx = '0;
        end else if (l_q.bit_idx != `SISI_BIT_IDX_MAX) begin
            l_d.bit_idx = l_q.bit_idx + 6'h01;
        end
        word_w = chan_word(l_d, l_d.chan);
        if (!l_d.cfg_s2.tx_en) begin
            l_d.dout = 1'b0;
            l_d.doe = 1'b0;
        end else if (!word_w[16]) begin
            l_d.dout = 1'b0;
            l_d.doe = ~l_d.cfg_s2.unused_slot_tristate_select;
        end else if (l_d.bit_idx < 6'h10) begin
            l_d.dout = word_w[~l_d.bit_idx[3:0]];
            l_d.doe = 1'b1;
        end else begin
            l_d.dout = 1'b0;
            l_d.doe = ~l_d.cfg_s2.padding_bits_tristate_select;
        end
    end

    always_ff @(posedge bclk or negedge reset_n) begin
        if (!reset_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end
    assign dout_o = l_q.dout;
    assign dout_oe = l_q.doe;

    // Checks on the interrupt side
    logic [`SISI_NSRC-1:0] raw_chk_q;
    logic [`SISI_NSRC-1:0] rise_chk;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            raw_chk_q <= '0;
        end else begin
            raw_chk_q <= raw_o;
        end
    end
    assign rise_chk = raw_o & ~raw_chk_q;

    a_state_on_rise: assert property (@(posedge clk) disable iff (!reset_n)
        (|rise_chk) |=> ((state_o & $past(rise_chk)) == $past(rise_chk)))
        else $error("state bit not set after raw rise");
    a_clear_state: assert property (@(posedge clk) disable iff (!reset_n)
        (|(source_clear_bit_i & ~rise_chk))
        |=> ((state_o & $past(source_clear_bit_i & ~rise_chk)) == '0))
        else $error("clear did not reset state");
    a_flag_and_en: assert property (@(posedge clk) disable iff (!reset_n)
        flag_o == (state_o & irq_enable_i))
        else $error("flag differs from state and enable");
    a_irq_active_lvl: assert property (@(posedge clk) disable iff (!reset_n)
        ((|flag_o) && irq_pin_drive_mode_i)
        |=> (irq_oe && (irq_o == $past(irq_pin_polarity_i))))
        else $error("active interrupt level wrong");
    a_irq_idle_lvl: assert property (@(posedge clk) disable iff (!reset_n)
        ((flag_o == '0) && irq_pin_drive_mode_i)
        |=> (irq_oe && (irq_o == !$past(irq_pin_polarity_i))))
        else $error("interrupt not deasserted with no flags");
    a_open_drain_pin: assert property (@(posedge clk) disable iff (!reset_n)
        !irq_pin_drive_mode_i
        |=> (!irq_o && (irq_oe == $past((|flag_o) ^ irq_pin_polarity_i))))
        else $error("open drain drive wrong");
    a_strength_pin: assert property (@(posedge clk) disable iff (!reset_n)
        irq_pin_drive_mode_i |=> (irq_strength_o == $past(irq_pin_drive_strength_i)))
        else $error("drive strength not passed in push-pull");
    a_therm_end_raw: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(temp_level_i.over_warn1) |-> raw_o[`SISI_SRC_TW1_END])
        else $error("warning one end source missing");
    // Shutdown events go through the full edge and state path, not just raw
    a_shdn_begin: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(temp_level_i.over_shdn) |=> state_o[`SISI_SRC_TSD_BGN])
        else $error("shutdown begin state not set");
    a_shdn_end: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(temp_level_i.over_shdn) |=> state_o[`SISI_SRC_TSD_END])
        else $error("shutdown end state not set");

    // A function result cannot be bit-selected, so the checks read a copy
    assign word_chk = chan_word(l_q, l_q.chan);

    // Checks on the link side
    a_tag_bit: assert property (@(posedge bclk) disable iff (!reset_n)
        (l_q.cfg_s2.tx_en && l_q.cfg_s2.interleave_en
            && (l_q.chan == l_q.cfg_s2.interleave_chan) && (l_q.bit_idx == 6'h00))
        |-> (dout_oe && (dout_o == (l_q.phase == SISI_PH_CURR))))
        else $error("interleave tag bit wrong");
    a_shifted_msb: assert property (@(posedge bclk) disable iff (!reset_n)
        (l_q.cfg_s2.tx_en && l_q.cfg_s2.interleave_en
            && (l_q.chan == l_q.cfg_s2.interleave_chan) && (l_q.bit_idx == 6'h01))
        |-> (dout_o == ((l_q.phase == SISI_PH_VOLT) ? l_q.tx_v[15] : l_q.tx_i[15])))
        else $error("sense word not shifted");
    a_pad_bits: assert property (@(posedge bclk) disable iff (!reset_n)
        (l_q.cfg_s2.tx_en && word_chk[16] && (l_q.bit_idx >= 6'h10))
        |-> (!dout_o && (dout_oe == !l_q.cfg_s2.padding_bits_tristate_select)))
        else $error("padding bits wrong");
    a_unused_chan: assert property (@(posedge bclk) disable iff (!reset_n)
        (l_q.cfg_s2.tx_en && !word_chk[16])
        |-> (!dout_o && (dout_oe == !l_q.cfg_s2.unused_slot_tristate_select)))
        else $error("unused channel drive wrong");
    a_status_load: assert property (@(posedge bclk) disable iff (!reset_n)
        frame_start |=> (l_q.stat == {$past(l_q.pend[15:2]), 2'b00}))
        else $error("status word not loaded at frame start");
    a_status_pulse: assert property (@(posedge bclk) disable iff (!reset_n)
        (frame_start && (new_ev == '0)) |=> (l_q.pend == '0))
        else $error("status bit held past one frame");
    a_phase_order: assert property (@(posedge bclk) disable iff (!reset_n)
        (frame_start && l_q.rx_new) |=> (l_q.phase == SISI_PH_VOLT))
        else $error("voltage word not first");
    // Without a new sample the current word repeats rather than a stale voltage word
    a_curr_repeat: assert property (@(posedge bclk) disable iff (!reset_n)
        (frame_start && !l_q.rx_new) |=> (l_q.phase == SISI_PH_CURR))
        else $error("current word not repeated");
endmodule

// >>> verification/sisi_host_model.sv
// Host model: frame clock master and capture of the serial sense output
`timescale 1ns/10ps
module sisi_host_model (
    input wire logic bclk,
    input wire logic reset_n,
    input wire logic dout,
    input wire logic dout_oe,
    output logic lrclk,
    output logic [15:0] w0,
    output logic [15:0] w1,
    output logic [1:0] oe_ok,
    output logic pad_oe,
    output logic pad_hi,
    output logic [7:0] frames
);
    logic [4:0] pos;
    logic last_q;
    logic seen;
    logic po;
    logic ph;
    logic [1:0] ok;
    logic [15:0] sh0;
    logic [15:0] sh1;
    // A released line shows the inverse of the last bit, so Hi-Z never reads as a match
    assign seen = dout_oe ? dout : ~last_q;
    always_ff @(negedge bclk or negedge reset_n) begin
        if (!reset_n) begin
            {lrclk, pos, last_q, po, ph, ok, sh0, sh1} <= {1'h1, 5'h00, 3'h0, 2'h3, 32'h0};
            {w0, w1, oe_ok, pad_oe, pad_hi, frames} <= '0;
        end else begin
            last_q <= seen;
            // Bit 0 stands from the second rising edge after the frame clock changes
            if (pos >= 5'h01 && pos <= 5'h10) begin
                if (lrclk) sh1 <= {sh1[14:0], seen};
                else sh0 <= {sh0[14:0], seen};
                if (!dout_oe) ok[lrclk] <= 1'h0;
            end else if (pos >= 5'h11) begin
                po <= po | dout_oe;
                ph <= ph | (dout_oe & dout);
            end
            pos <= (pos == 5'h17) ? 5'h00 : pos + 5'h01;
            // Two frames per sense sample; the bench paces samples to match
            if (pos == 5'h17) lrclk <= ~lrclk;
            if (pos == 5'h17 && lrclk) begin
                {w0, w1, oe_ok, pad_oe, pad_hi} <= {sh0, sh1, ok, po, ph};
                {ok, po, ph} <= 4'hc;
                frames <= frames + 8'h01;
            end
        end
    end
endmodule

// >>> verification/tb_sense_interleave_status_irq.sv
// Testbench for the sense interleave, status word and interrupt block
`timescale 1ns/10ps
module tb_sense_interleave_status_irq;
    import sisi_pkg::*;
    logic clk = 0;
    logic bclk = 0;
    logic reset_n = 0;
    logic mode = 0;
    logic pol = 0;
    logic irq, oe, lrclk, dout, dout_oe, pad_oe, pad_hi;
    logic [1:0] strg = 2'h2;
    logic [1:0] strg_o, oe_ok;
    logic [15:0] en = '0;
    logic [15:0] clear_v = '0;
    logic [15:0] raw, st, flg, w0, w1;
    logic [7:0] frames;
    sisi_misc_raw_t misc = '0;
    sisi_temp_t temp = '0;
    sisi_sense_t sense = '0;
    sisi_tx_cfg_t cfg = '0;
    int fail_count = 0;
    int checked = 0;
    always #20 clk = ~clk;
    always #7.5 bclk = ~bclk;
    sisi_top dut (.clk(clk), .reset_n(reset_n), .misc_raw_i(misc), .temp_level_i(temp),
        .irq_enable_i(en), .source_clear_bit_i(clear_v), .irq_pin_drive_mode_i(mode),
        .irq_pin_polarity_i(pol), .irq_pin_drive_strength_i(strg), .sense_i(sense),
        .tx_cfg_i(cfg), .raw_o(raw), .state_o(st), .flag_o(flg), .irq_o(irq), .irq_oe(oe),
        .irq_strength_o(strg_o), .bclk(bclk), .lrclk_i(lrclk), .dout_o(dout),
        .dout_oe(dout_oe));
    sisi_host_model host (.bclk(bclk), .reset_n(reset_n), .dout(dout), .dout_oe(dout_oe),
        .lrclk(lrclk), .w0(w0), .w1(w1), .oe_ok(oe_ok), .pad_oe(pad_oe), .pad_hi(pad_hi),
        .frames(frames));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait for the host to publish the next complete frame
    task automatic next_frame();
        logic [7:0] f;
        int k;
        f = frames;
        for (k = 0; k < 200 && frames === f; k++) @(negedge clk);
        if (k >= 200) begin
            fail_count++;
            print_verdict();
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic chk_pin(logic act);
        chk("irq", mode ? !(act ^ pol) : 1'h0, irq);
        chk("irq_oe", mode ? 1'h1 : act ^ pol, oe);
        chk("strength", mode ? strg : 2'h0, strg_o);
    endtask
    task automatic t_pin();
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            {mode, pol} <= c[1:0];
            misc.spk_ovc <= 1'h1;
            en <= 16'h0000;
            repeat (3) @(negedge clk);
            chk("raw", 16'h0008, raw);
            chk("state", 16'h0008, st);
            chk("flag_off", 16'h0000, flg);
            chk_pin(1'h0);
            @(posedge clk);
            en <= 16'h0008;
            @(negedge clk);
            chk("flag_on", 16'h0008, flg);
            repeat (2) @(negedge clk);
            chk_pin(1'h1);
            @(posedge clk);
            clear_v <= 16'h0008;
            misc.spk_ovc <= 1'h0;
            @(posedge clk);
            clear_v <= 16'h0000;
            repeat (3) @(negedge clk);
            chk("cleared", 16'h0000, st | flg);
            chk_pin(1'h0);
        end
    endtask
    task automatic t_therm();
        int bg[3] = '{0, 11, 9};
        int nd[3] = '{1, 10, 8};
        for (int t = 0; t < 3; t++) begin
            @(posedge clk);
            temp <= 3'h4 >> t;
            repeat (2) @(negedge clk);
            chk("t_begin", 16'h0001 << bg[t], st);
            @(posedge clk);
            temp <= 3'h0;
            repeat (2) @(negedge clk);
            chk("t_end", (16'h0001 << bg[t]) | (16'h0001 << nd[t]), st);
            @(posedge clk);
            clear_v <= 16'hffff;
            @(posedge clk);
            clear_v <= 16'h0000;
        end
    endtask
    // Config may change only while the output is off
    task automatic set_cfg(logic pad, logic unused, sisi_chan_type_t c1);
        @(posedge clk);
        cfg.tx_en <= 1'h0;
        repeat (3) @(posedge clk);
        cfg <= {3'h2, pad, unused, c1, SISI_CT_VOLT};
        repeat (3) @(posedge clk);
        cfg.tx_en <= 1'h1;
        repeat (3) next_frame();
    endtask
    task automatic t_sense();
        logic [15:0] v;
        logic [15:0] i;
        v = 16'ha5c3;
        i = 16'h3c5a;
        @(posedge clk);
        sense <= {1'h1, v, i};
        @(posedge clk);
        sense.valid <= 1'h0;
        for (int f = 0; f < 5 && w0 !== {1'h0, v[15:1]}; f++) next_frame();
        chk("volt_word", {1'h0, v[15:1]}, w0);
        next_frame();
        chk("curr_word", {1'h1, i[15:1]}, w0);
        chk("chan_oe", 16'h0003, oe_ok);
        chk("pad_hiz", 16'h0000, {pad_oe, pad_hi});
    endtask
    task automatic t_status();
        int idx[10] = '{2, 3, 5, 4, 6, 7, 12, 13, 14, 15};
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            misc <= 10'h001 << k;
            for (int f = 0; f < 5 && w1 === 16'h0000; f++) next_frame();
            chk("status", 16'h0001 << idx[k], w1);
            next_frame();
            chk("status_end", 16'h0000, w1);
            @(posedge clk);
            misc <= '0;
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        chk("rst_state", 16'h0000, st);
        chk("rst_pin", 16'h0000, {irq, oe});
        reset_n <= 1'h1;
        repeat (2) @(posedge clk);
        t_pin();
        t_therm();
        set_cfg(1'h1, 1'h0, SISI_CT_STAT);
        t_sense();
        t_status();
        set_cfg(1'h0, 1'h1, SISI_CT_NONE);
        next_frame();
        chk("oe_unused", 16'h0001, oe_ok);
        chk("pad_zero", 16'h0002, {pad_oe, pad_hi});
        print_verdict();
    end
endmodule
